// *** pfct_core.sv ***
// Boost power-factor stage timing and control: PWM, sample triggers, current loop,
// fixed-rate tasks, filters, bandwidth scheduling and relay sequencing.
// Assumes a 250 MHz clock, synchronous comparator inputs and an external converter
// that returns results with a done strobe.
`timescale 1ns/1ps
`include "pfct_defines.svh"

module pfct_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [15:0] duty_compare_value,
  input wire logic peak_current_trap,
  input wire logic zero_current_detect,
  input wire logic discontinuous_mode,
  input wire logic adc_current_done,
  input wire logic [11:0] adc_current_data,
  input wire logic adc_voltage_done,
  input wire logic [11:0] adc_vin_data,
  input wire logic [11:0] adc_vbulk_data,
  input wire logic [11:0] adc_aux_data,
  input wire logic [11:0] cfg_bw_low_thresh,
  input wire logic [11:0] cfg_bw_high_thresh,
  input wire logic [11:0] cfg_ind_breakpoint,
  input wire logic [15:0] cfg_gain_hi_bw,
  input wire logic [15:0] cfg_gain_lo_bw,
  input wire logic [15:0] cfg_seg0_slope,
  input wire logic [15:0] cfg_seg1_slope,
  input wire logic [11:0] cfg_vbulk_target,
  input wire logic [11:0] cfg_vbulk_over,
  input wire logic [11:0] cfg_vbulk_under,
  input wire logic [11:0] cfg_vbulk_restart,
  input wire logic [7:0] cfg_zero_ref,
  input wire logic [15:0] cfg_restart_ticks,
  input wire logic signed [15:0] cfg_lp_b0,
  input wire logic signed [15:0] cfg_lp_b1,
  input wire logic signed [15:0] cfg_lp_a1,
  input wire logic signed [15:0] cfg_lp_a2,
  input wire logic signed [15:0] cfg_nt_b0,
  input wire logic signed [15:0] cfg_nt_b1,
  input wire logic signed [15:0] cfg_nt_a1,
  input wire logic signed [15:0] cfg_nt_a2,
  output logic pwm_out,
  output logic relay_close,
  output logic current_trigger,
  output logic voltage_trigger,
  output logic current_loop_start,
  output logic fixed_rate_tick,
  output logic zero_ref_pwm,
  output logic [15:0] sample_trigger_compare_value,
  output logic [15:0] avg_current,
  output logic [15:0] loop_gain,
  output logic bw_low_active,
  output logic signed [15:0] vin_smoothed,
  output logic signed [15:0] vbulk_filtered,
  output logic [5:0] state_out
);

  // ----------------------------------------------------------------
  // Main timer and replica timer
  // ----------------------------------------------------------------
  localparam logic [15:0] SW_PERIOD = 16'(`PFCT_SW_PERIOD);
  localparam logic [15:0] FF_PERIOD = 16'(`PFCT_FF_PERIOD);

  logic [15:0] main_cnt_q, replica_cnt_q, duty_q;
  logic trap_q, pwm_q, arm_q;
  logic switching_en, gate_en;
  logic main_wrap, pwm_rise;
  logic [15:0] mid_off;
  logic [16:0] off_sum;

  assign main_wrap = (main_cnt_q == SW_PERIOD - 16'h0001);
  // Duty latched at wrap so a mid-cycle change cannot glitch the on-time
  assign sample_trigger_compare_value = {1'b0, duty_q[15:1]};
  assign off_sum = {1'b0, duty_q} + {1'b0, SW_PERIOD};
  assign mid_off = off_sum[16:1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_cnt_q <= 16'h0000;
      replica_cnt_q <= 16'h0000;
      duty_q <= `PFCT_DUTY_RST;
      pwm_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      main_cnt_q <= main_wrap ? 16'h0000 : main_cnt_q + 16'h0001;
      replica_cnt_q <= main_wrap ? 16'h0000 : replica_cnt_q + 16'h0001;
      if (main_wrap) begin
        duty_q <= (duty_compare_value > SW_PERIOD) ? SW_PERIOD : duty_compare_value;
      end
      // Switching starts only at a period boundary so the first pulse is never cut short
      arm_q <= switching_en && (arm_q || main_wrap);
      pwm_q <= gate_en && !trap_q && !peak_current_trap && (main_cnt_q < duty_q);
    end
  end

  // Trap holds until the next period so one noisy edge cannot re-fire the switch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trap_q <= 1'b0;
    end else if (peak_current_trap) begin
      trap_q <= 1'b1;
    end else if (main_wrap) begin
      trap_q <= 1'b0;
    end
  end

  assign pwm_out = pwm_q;
  assign pwm_rise = switching_en && main_wrap && (duty_q != 16'h0000);
  assign gate_en = switching_en && arm_q;

  // ----------------------------------------------------------------
  // Conversion triggers
  // ----------------------------------------------------------------
  logic cur_trig_q, volt_trig_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_trig_q <= 1'b0;
      volt_trig_q <= 1'b0;
    end else begin
      cur_trig_q <= gate_en && (main_cnt_q == sample_trigger_compare_value);
      volt_trig_q <= (replica_cnt_q == mid_off);
    end
  end

  assign current_trigger = cur_trig_q;
  assign voltage_trigger = volt_trig_q;

  // ----------------------------------------------------------------
  // Discontinuous conduction capture and average correction
  // ----------------------------------------------------------------
  logic [15:0] cond_time;
  logic [31:0] avg_prod;
  logic [15:0] avg_dcm;

  pfct_capture u_capture (
    .clock(clock),
    .rst_n(rst_n),
    .enable(discontinuous_mode),
    .pwm_rise(pwm_rise),
    .zero_current_detect(zero_current_detect),
    .conduction_time(cond_time),
    .capture_valid()
  );

  // A constant divide; it folds into a multiply so no division unit is needed
  assign avg_prod = {20'h00000, adc_current_data} * {16'h0000, cond_time};
  assign avg_dcm = 16'(avg_prod / {16'h0000, SW_PERIOD});

  // ----------------------------------------------------------------
  // Current loop pass: gain schedule and hysteresis
  // ----------------------------------------------------------------
  logic [15:0] avg_q, gain_q;
  logic start_q;
  pfct_pkg::pfct_bw_t bw_q, bw_d;
  logic [15:0] base_gain, seg_slope;
  logic [27:0] sched;
  logic [15:0] avg_cmp;

  // Decide on the average being taken now, not the one from the previous pass
  assign avg_cmp = discontinuous_mode ? avg_dcm : {4'h0, adc_current_data};
  always_comb begin
    bw_d = bw_q;
    if (bw_q == pfct_pkg::PFCT_BW_HIGH && avg_cmp > {4'h0, cfg_bw_high_thresh}) begin
      bw_d = pfct_pkg::PFCT_BW_LOW;
    end else if (bw_q == pfct_pkg::PFCT_BW_LOW && avg_cmp < {4'h0, cfg_bw_low_thresh}) begin
      bw_d = pfct_pkg::PFCT_BW_HIGH;
    end
  end

  assign base_gain = (bw_q == pfct_pkg::PFCT_BW_LOW) ? cfg_gain_lo_bw : cfg_gain_hi_bw;
  assign seg_slope = (adc_current_data < cfg_ind_breakpoint) ? cfg_seg0_slope : cfg_seg1_slope;
  // Gain scales with the inductance drop: base plus slope times current, Q12
  assign sched = 28'(base_gain) + 28'(({12'h000, seg_slope} * {16'h0000, adc_current_data}) >> 12);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avg_q <= 16'h0000;
      gain_q <= 16'h0000;
      start_q <= 1'b0;
      bw_q <= pfct_pkg::PFCT_BW_HIGH;
    end else begin
      start_q <= adc_current_done;
      if (adc_current_done) begin
        avg_q <= avg_cmp;
        gain_q <= (sched > 28'h000ffff) ? 16'hffff : sched[15:0];
        bw_q <= bw_d;
      end
    end
  end

  assign current_loop_start = start_q;
  assign avg_current = avg_q;
  assign loop_gain = gain_q;
  assign bw_low_active = (bw_q == pfct_pkg::PFCT_BW_LOW);

  // ----------------------------------------------------------------
  // Fixed-rate tick and comparator reference
  // ----------------------------------------------------------------
  logic [15:0] ff_cnt_q;
  logic ff_tick_q;
  logic [7:0] ref_cnt_q;
  logic ref_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ff_cnt_q <= 16'h0000;
      ff_tick_q <= 1'b0;
      ref_cnt_q <= 8'h00;
      ref_q <= 1'b0;
    end else begin
      ff_tick_q <= (ff_cnt_q == FF_PERIOD - 16'h0001);
      ff_cnt_q <= (ff_cnt_q == FF_PERIOD - 16'h0001) ? 16'h0000 : ff_cnt_q + 16'h0001;
      ref_cnt_q <= ref_cnt_q + 8'h01;
      ref_q <= (ref_cnt_q < cfg_zero_ref);
    end
  end

  assign fixed_rate_tick = ff_tick_q;
  assign zero_ref_pwm = ref_q;

  // ----------------------------------------------------------------
  // Filters: two cascaded sections per path, run on the tick
  // ----------------------------------------------------------------
  logic signed [15:0] vin_s, vbulk_s, lp_mid, nt_mid;
  logic lp_mid_v, nt_mid_v;
  logic [11:0] vin_hold_q, vbulk_hold_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vin_hold_q <= 12'h000;
      vbulk_hold_q <= 12'h000;
    end else if (adc_voltage_done) begin
      vin_hold_q <= adc_vin_data;
      vbulk_hold_q <= adc_vbulk_data;
    end
  end

  assign vin_s = {4'h0, vin_hold_q};
  assign vbulk_s = {4'h0, vbulk_hold_q};

  // Symmetric numerators: b2 reuses b0 for both paths
  pfct_biquad u_lp0 (.clock(clock), .rst_n(rst_n), .in_valid(ff_tick_q), .in_data(vin_s),
    .b0(cfg_lp_b0), .b1(cfg_lp_b1), .b2(cfg_lp_b0), .a1(cfg_lp_a1), .a2(cfg_lp_a2),
    .out_valid(lp_mid_v), .out_data(lp_mid));
  pfct_biquad u_lp1 (.clock(clock), .rst_n(rst_n), .in_valid(lp_mid_v), .in_data(lp_mid),
    .b0(cfg_lp_b0), .b1(cfg_lp_b1), .b2(cfg_lp_b0), .a1(cfg_lp_a1), .a2(cfg_lp_a2),
    .out_valid(), .out_data(vin_smoothed));
  pfct_biquad u_nt0 (.clock(clock), .rst_n(rst_n), .in_valid(ff_tick_q), .in_data(vbulk_s),
    .b0(cfg_nt_b0), .b1(cfg_nt_b1), .b2(cfg_nt_b0), .a1(cfg_nt_a1), .a2(cfg_nt_a2),
    .out_valid(nt_mid_v), .out_data(nt_mid));
  pfct_biquad u_nt1 (.clock(clock), .rst_n(rst_n), .in_valid(nt_mid_v), .in_data(nt_mid),
    .b0(cfg_nt_b0), .b1(cfg_nt_b1), .b2(cfg_nt_b0), .a1(cfg_nt_a1), .a2(cfg_nt_a2),
    .out_valid(), .out_data(vbulk_filtered));

  // ----------------------------------------------------------------
  // Sequencer, stepped on the fixed-rate tick
  // ----------------------------------------------------------------
  pfct_pkg::pfct_state_t st_q, st_d;
  logic [15:0] wait_q;
  logic relay_q;
  logic [11:0] vb;

  assign vb = vbulk_hold_q;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      pfct_pkg::PFCT_ST_IDLE: if (enable) st_d = pfct_pkg::PFCT_ST_RELAY;
      pfct_pkg::PFCT_ST_RELAY: st_d = pfct_pkg::PFCT_ST_RUN;
      pfct_pkg::PFCT_ST_RUN: begin
        if (vb < cfg_vbulk_under) st_d = pfct_pkg::PFCT_ST_FAULT;
        else if (vb > cfg_vbulk_over) st_d = pfct_pkg::PFCT_ST_OVER;
      end
      pfct_pkg::PFCT_ST_OVER: begin
        if (vb < cfg_vbulk_under) st_d = pfct_pkg::PFCT_ST_FAULT;
        else if (vb <= cfg_vbulk_target) st_d = pfct_pkg::PFCT_ST_RUN;
      end
      pfct_pkg::PFCT_ST_FAULT: st_d = pfct_pkg::PFCT_ST_RESTART;
      pfct_pkg::PFCT_ST_RESTART: begin
        if (vb < cfg_vbulk_restart) st_d = pfct_pkg::PFCT_ST_IDLE;
        else if (wait_q >= cfg_restart_ticks) st_d = pfct_pkg::PFCT_ST_RUN;
      end
      default: st_d = pfct_pkg::PFCT_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= pfct_pkg::PFCT_ST_IDLE;
      wait_q <= 16'h0000;
      relay_q <= 1'b0;
    end else if (ff_tick_q) begin
      st_q <= st_d;
      wait_q <= (st_q == pfct_pkg::PFCT_ST_RESTART) ? wait_q + 16'h0001 : 16'h0000;
      if (st_d == pfct_pkg::PFCT_ST_RELAY) relay_q <= 1'b1;
      else if (st_d == pfct_pkg::PFCT_ST_IDLE) relay_q <= 1'b0;
    end
  end

  assign switching_en = relay_q && (st_q == pfct_pkg::PFCT_ST_RUN);
  assign relay_close = relay_q;
  assign state_out = st_q;

endmodule

// *** pfct_defines.svh ***
// Timing counts, field widths and reset values for the boost-stage timing control.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef PFCT_DEFINES_SVH
`define PFCT_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and switching timing
// ----------------------------------------------------------------
`define PFCT_CLK_KHZ 250000
`define PFCT_FSW_KHZ 65
`define PFCT_FF_HZ 6500
// Switching period in cycles, rounded down so the rate never falls below 65 kHz
`define PFCT_SW_PERIOD ((`PFCT_CLK_KHZ) / (`PFCT_FSW_KHZ))
// Fixed-rate tick period in cycles
`define PFCT_FF_PERIOD ((`PFCT_CLK_KHZ * 1000) / (`PFCT_FF_HZ))
`define PFCT_CNT_W 16
`define PFCT_FF_W 16

// ----------------------------------------------------------------
// Data widths
// ----------------------------------------------------------------
`define PFCT_ADC_W 12
`define PFCT_COEF_W 16
`define PFCT_REF_W 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PFCT_DUTY_RST 16'h0000
`define PFCT_ZREF_RST 8'h08
`define PFCT_RESTART_TICKS 16'h0a28

`endif

// *** pfct_pkg.sv ***
// Types shared by the boost-stage timing control.
// Assumes pfct_defines.svh is compiled alongside.
package pfct_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    PFCT_ST_IDLE    = 6'b000001,
    PFCT_ST_RELAY   = 6'b000010,
    PFCT_ST_RUN     = 6'b000100,
    PFCT_ST_OVER    = 6'b001000,
    PFCT_ST_FAULT   = 6'b010000,
    PFCT_ST_RESTART = 6'b100000
  } pfct_state_t;

  // Current-loop bandwidth selection
  typedef enum logic [1:0] {
    PFCT_BW_HIGH = 2'b01,
    PFCT_BW_LOW  = 2'b10
  } pfct_bw_t;

endpackage

// *** pfct_biquad.sv ***
// One second-order recursive section, direct form I, signed fixed point (Q2.14).
// Assumes the caller presents one sample per strobe and holds coefficients stable.
`timescale 1ns/1ps
`include "pfct_defines.svh"

module pfct_biquad (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic signed [15:0] in_data,
  input wire logic signed [15:0] b0,
  input wire logic signed [15:0] b1,
  input wire logic signed [15:0] b2,
  input wire logic signed [15:0] a1,
  input wire logic signed [15:0] a2,
  output logic out_valid,
  output logic signed [15:0] out_data
);

  logic signed [15:0] x1_q, x2_q, y1_q, y2_q;
  logic signed [35:0] acc;
  logic signed [15:0] y_new;

  // Feedback terms subtracted; a1/a2 hold the denominator coefficients as printed
  assign acc = 36'(b0 * in_data) + 36'(b1 * x1_q) + 36'(b2 * x2_q)
             - 36'(a1 * y1_q) - 36'(a2 * y2_q);
  // Saturation is not applied; coefficients must keep the section stable
  assign y_new = acc[29:14];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      x1_q <= 16'sh0000;
      x2_q <= 16'sh0000;
      y1_q <= 16'sh0000;
      y2_q <= 16'sh0000;
      out_valid <= 1'b0;
      out_data <= 16'sh0000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        x1_q <= in_data;
        x2_q <= x1_q;
        y1_q <= y_new;
        y2_q <= y1_q;
        out_data <= y_new;
      end
    end
  end

endmodule

// *** pfct_capture.sv ***
// Conduction-time capture timer for discontinuous operation.
// Assumes the zero-current comparator output is synchronous to clock.
`timescale 1ns/1ps
`include "pfct_defines.svh"

module pfct_capture (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic pwm_rise,
  input wire logic zero_current_detect,
  output logic [15:0] conduction_time,
  output logic capture_valid
);

  logic [15:0] cnt_q;
  logic zcd_q;
  logic running_q;
  logic zcd_fall;

  assign zcd_fall = zcd_q & ~zero_current_detect;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      zcd_q <= 1'b0;
      running_q <= 1'b0;
      conduction_time <= 16'h0000;
      capture_valid <= 1'b0;
    end else begin
      zcd_q <= zero_current_detect;
      capture_valid <= 1'b0;
      if (enable && pwm_rise) begin
        cnt_q <= 16'h0000;
        running_q <= 1'b1;
      end else if (running_q) begin
        cnt_q <= cnt_q + 16'h0001;
        if (zcd_fall) begin
          conduction_time <= cnt_q;
          capture_valid <= 1'b1;
          running_q <= 1'b0;
        end
      end
    end
  end

endmodule

// *** pfct_stage_model.sv ***
// Behavioural power stage: peak-current and near-zero current comparators.
// Assumes the switch gate is pwm_out and the bench asks for over-current by trap_cmd.
`timescale 1ns/1ps

module pfct_stage_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pwm_out,
  input wire logic trap_cmd,
  input wire logic [15:0] tail_cycles,
  output logic peak_current_trap,
  output logic zero_current_detect
);
  // ----------------------------------------------------------------
  // Comparator outputs
  // ----------------------------------------------------------------
  logic [15:0] tail_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tail_q <= 16'h0000;
      peak_current_trap <= 1'b0;
      zero_current_detect <= 1'b0;
    end else begin
      // Current can only pass the limit while the switch conducts
      peak_current_trap <= trap_cmd && pwm_out;
      // Current stays above the near-zero level for the on-time plus a tail
      if (pwm_out) begin
        tail_q <= tail_cycles;
      end else if (tail_q != 16'h0000) begin
        tail_q <= tail_q - 16'h0001;
      end
      zero_current_detect <= pwm_out || (tail_q > 16'h0001);
    end
  end
endmodule

// *** pfct_core_sva.sv ***
// Port-level checks on the boost-stage timing control.
// Assumes it is bound into pfct_core; one clock domain.
`timescale 1ns/1ps
`include "pfct_defines.svh"

module pfct_core_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic peak_current_trap,
  input wire logic adc_current_done,
  input wire logic [11:0] cfg_bw_low_thresh,
  input wire logic [11:0] cfg_bw_high_thresh,
  input wire logic pwm_out,
  input wire logic relay_close,
  input wire logic current_trigger,
  input wire logic voltage_trigger,
  input wire logic current_loop_start,
  input wire logic fixed_rate_tick,
  input wire logic [15:0] avg_current,
  input wire logic bw_low_active,
  input wire logic [5:0] state_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Tick spacing counter
  // ----------------------------------------------------------------
  logic [15:0] gap_q;
  logic seen_q;
  logic cut_q;

  // A peak trap ends the on-time early, so the mid on-time trigger may then meet a low gate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cut_q <= 1'b0;
    end else if (peak_current_trap) begin
      cut_q <= 1'b1;
    end else if (pwm_out) begin
      cut_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (fixed_rate_tick) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_loop_after_done: assert property (adc_current_done |=> current_loop_start)
    else $error("current loop did not start after a current sample");
  chk_loop_has_cause: assert property (current_loop_start |-> $past(adc_current_done))
    else $error("current loop started without a sample");
  chk_trap_cuts_pwm: assert property (peak_current_trap |=> !pwm_out)
    else $error("gate still high after peak trap");
  chk_relay_before_pwm: assert property (pwm_out |-> relay_close)
    else $error("switching with bypass relay open");
  chk_relay_open_idle: assert property ($fell(relay_close) |-> state_out == pfct_pkg::PFCT_ST_IDLE)
    else $error("relay opened outside idle");
  chk_over_holds_off: assert property ((state_out == pfct_pkg::PFCT_ST_OVER) [*2] |-> !pwm_out)
    else $error("gate high during overshoot");
  chk_fault_holds_off: assert property ((state_out == pfct_pkg::PFCT_ST_FAULT
      || state_out == pfct_pkg::PFCT_ST_RESTART) [*2] |-> !pwm_out)
    else $error("gate high during undervoltage stop");
  chk_tick_spacing: assert property (fixed_rate_tick && seen_q |-> gap_q == `PFCT_FF_PERIOD - 1)
    else $error("fixed-rate tick spacing wrong");
  chk_itrig_on_time: assert property (current_trigger && !cut_q |-> pwm_out)
    else $error("current trigger outside on-time");
  chk_vtrig_off_time: assert property (voltage_trigger |-> !pwm_out)
    else $error("voltage trigger outside off-time");
  chk_bw_down_cause: assert property ($rose(bw_low_active) |-> avg_current > {4'h0, cfg_bw_high_thresh})
    else $error("bandwidth lowered below upper threshold");
  chk_bw_up_cause: assert property ($fell(bw_low_active) |-> avg_current < {4'h0, cfg_bw_low_thresh})
    else $error("bandwidth raised above lower threshold");
endmodule

// *** pfct_average_current_timing_control_bench.sv ***
// Self-checking bench for pfct_core with a behavioural power stage.
// Assumes pfct_pkg, the design files and the checker are compiled first.
`timescale 1ns/1ps
`include "pfct_defines.svh"

module pfct_average_current_timing_control_bench;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  localparam int PER = `PFCT_SW_PERIOD;
  localparam int PFF = `PFCT_FF_PERIOD;
  localparam int DUTY = 1000;
  localparam logic [11:0] HD [5] = '{12'h180, 12'h400, 12'h280, 12'h180, 12'h080};
  localparam logic [15:0] HG [5] = '{16'h1018, 16'h0000, 16'h0850, 16'h0818, 16'h0000};
  localparam logic HB [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  logic clock = 1'b0, rst_n = 1'b0, enable = 1'b1, discontinuous_mode = 1'b0, trap_cmd = 1'b0;
  logic adc_current_done = 1'b0, adc_voltage_done = 1'b0;
  logic [11:0] adc_current_data = 12'h000, adc_vin_data = 12'h400, adc_vbulk_data = 12'h000;
  logic [11:0] adc_aux_data = 12'h000, cfg_bw_low_thresh = 12'h100, cfg_bw_high_thresh = 12'h300;
  logic [11:0] cfg_ind_breakpoint = 12'h200, cfg_vbulk_target = 12'h600, cfg_vbulk_over = 12'h700;
  logic [11:0] cfg_vbulk_under = 12'h400, cfg_vbulk_restart = 12'h300;
  logic [15:0] duty_compare_value = 16'(DUTY), cfg_restart_ticks = 16'h0004, tail_cycles = 16'h0256;
  logic [15:0] cfg_gain_hi_bw = 16'h1000, cfg_gain_lo_bw = 16'h0800;
  logic [15:0] cfg_seg0_slope = 16'h0100, cfg_seg1_slope = 16'h0200;
  logic [7:0] cfg_zero_ref = 8'h08;
  logic signed [15:0] cfg_lp_b0 = 16'h0400, cfg_lp_b1 = 16'h0800, cfg_lp_a1 = 16'h0000;
  logic signed [15:0] cfg_lp_a2 = 16'h0000, cfg_nt_b0 = 16'h4000, cfg_nt_b1 = 16'h0000;
  logic signed [15:0] cfg_nt_a1 = 16'h0000, cfg_nt_a2 = 16'h0000;
  wire logic peak_current_trap, zero_current_detect, pwm_out, relay_close, current_trigger;
  wire logic voltage_trigger, current_loop_start, fixed_rate_tick, zero_ref_pwm, bw_low_active;
  wire logic [15:0] sample_trigger_compare_value, avg_current, loop_gain;
  wire logic signed [15:0] vin_smoothed, vbulk_filtered;
  wire logic [5:0] state_out;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  pfct_core pfct_core_inst (.*);
  pfct_stage_model pfct_stage_model_inst (.*);

  initial begin
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic samp(input logic [11:0] d);
    @(posedge clock);
    adc_current_data <= d;
    adc_current_done <= 1'b1;
    @(posedge clock);
    adc_current_done <= 1'b0;
    #1;
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (fixed_rate_tick !== 1'b1 && n < 40000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bw();
    for (int i = 0; i < 5; i++) begin
      samp(HD[i]);
      chk({15'h0, current_loop_start}, 16'h0001);
      chk(avg_current, {4'h0, HD[i]});
      chk({15'h0, bw_low_active}, {15'h0, HB[i]});
      if (HG[i] != 16'h0000) chk(loop_gain, HG[i]);
    end
  endtask

  task automatic t_zref();
    int n;
    n = 0;
    repeat (256) begin
      @(posedge clock);
      #1;
      if (zero_ref_pwm === 1'b1) n++;
    end
    chk(16'(n), {8'h0, cfg_zero_ref});
  endtask

  task automatic t_start();
    int n;
    @(posedge clock);
    discontinuous_mode <= 1'b1;
    adc_current_data <= 12'h100;
    adc_vbulk_data <= 12'h600;
    adc_voltage_done <= 1'b1;
    @(posedge clock);
    adc_voltage_done <= 1'b0;
    wait_tick(n);
    repeat (2) @(posedge clock);
    #1;
    chk({10'h0, state_out}, 16'h0002);
    chk({14'h0, relay_close, pwm_out}, 16'h0002);
    wait_tick(n);
    chk(16'(n + 2), 16'(PFF));
    repeat (2) @(posedge clock);
    #1;
    chk({10'h0, state_out}, 16'h0004);
    chk(vin_smoothed, 16'h0014);
    chk(vbulk_filtered, 16'h0600);
    n = 0;
    while (pwm_out !== 1'b1 && n < 8000) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  // Entered just after a rising gate edge and left at the next one
  task automatic t_period(input logic trap);
    int hi, ti, vi, ls;
    hi = 1;
    ti = -1;
    vi = -1;
    ls = 0;
    for (int k = 1; k <= PER; k++) begin
      @(posedge clock);
      adc_current_done <= (ti > 0 && k == ti + 2);
      trap_cmd <= trap && k < 20;
      #1;
      if (k < PER && pwm_out === 1'b1) hi++;
      if (current_trigger === 1'b1) ti = k;
      if (voltage_trigger === 1'b1) vi = k;
      if (current_loop_start === 1'b1) ls++;
    end
    chk({15'h0, pwm_out}, 16'h0001);
    if (trap) begin
      chk({15'h0, hi < 8}, 16'h0001);
    end else begin
      chk(16'(hi), 16'(DUTY));
      chk(16'(ti), 16'(DUTY / 2));
      chk(16'(vi), 16'((DUTY + PER) / 2));
      chk(16'(ls), 16'h0001);
      chk(sample_trigger_compare_value, 16'(DUTY / 2));
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk({9'h0, state_out, relay_close}, 16'h0002);
    t_bw();
    t_zref();
    t_start();
    t_period(1'b1);
    t_period(1'b0);
    t_period(1'b0);
    // Conduction of about 1600 cycles scales a 0x100 sample down to 0x6a
    chk(avg_current, 16'h006a);
    conclude();
  end
endmodule

bind pfct_core pfct_core_sva pfct_core_sva_inst (.*);
